// ### hw/rri_contact.sv
// One contact input: three-stage synchroniser, stable level and pulse width check.
// Assumes a dry contact, closed = 1, with any bounce shorter than one clock.
module rri_contact #(
    parameter int CNT_W = 25
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             pin,
    input  wire logic [CNT_W-1:0] min_cyc,
    output logic                  lvl,
    output logic                  rise,
    output logic                  long_pulse
);
    logic             s1_q, s2_q, s3_q;
    logic             lvl_q, rise_q, long_q;
    logic [CNT_W-1:0] cnt_q;
    wire              agree   = (s2_q == s3_q);
    wire              cnt_sat = (cnt_q == {CNT_W{1'b1}});

    ////////////////////////////////////////////////////////////////////////////
    // Sample and measure; only the third stage and its partner decide a change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            s3_q   <= 1'b0;
            lvl_q  <= 1'b0;
            rise_q <= 1'b0;
            long_q <= 1'b0;
            cnt_q  <= '0;
        end else begin
            s1_q   <= pin;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            lvl_q  <= agree ? s3_q : lvl_q;
            rise_q <= agree && s3_q && !lvl_q;
            // Count lags the closed cycles by one, so >= means closed longer than min_cyc
            long_q <= agree && !s3_q && lvl_q && (cnt_q >= min_cyc);
            cnt_q  <= !lvl_q ? '0 : (cnt_sat ? cnt_q : cnt_q + 1'b1);  // Saturates, never wraps
        end
    end

    assign lvl        = lvl_q;
    assign rise       = rise_q;
    assign long_pulse = long_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_long_width;
        (agree && !s3_q && lvl_q && cnt_q >= min_cyc) |=> long_pulse ##1 !long_pulse;
    endproperty
    a_long_width: assert property (p_long_width) else $error("long pulse not flagged");

    property p_short_none;
        (agree && !s3_q && lvl_q && cnt_q < min_cyc) |=> !long_pulse;
    endproperty
    a_short_none: assert property (p_short_none) else $error("short pulse flagged");

endmodule : rri_contact

// ### hw/rri_top.sv
// Remote run input logic: contacts to run, inhibit, remote mode, frequency and reset.
// Assumes registers written over a plain strobe port and drive fault inputs on clk.
//
// Local design decisions: the register offsets and the plain strobed port.
module rri_top #(
    parameter int unsigned PULSE_MIN_CYC = rri_pkg::PULSE_MIN_CYC_DEF
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire rri_pkg::rri_pins_t            pins,
    input  wire logic [rri_pkg::ADDR_W-1:0]    addr,
    input  wire logic [rri_pkg::DATA_W-1:0]    wdata,
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    output logic      [rri_pkg::DATA_W-1:0]    rdata_q,
    input  wire logic                          fault_trip,
    input  wire logic                          fault_cond,
    output logic                               run_fwd_q,
    output logic                               run_rev_q,
    output logic                               output_inhibit_q,
    output logic                               remote_mode_q,
    output logic      [rri_pkg::FREQ_W-1:0]    freq_ref_q,
    output logic                               preset_active_q,
    output logic                               fault_q,
    output logic                               fault_reset_q
);
    import rri_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Contact inputs
    logic [PIN_N-1:0] pin_v;
    logic [PIN_N-1:0] lvl_v;
    logic [PIN_N-1:0] rise_v;
    logic [PIN_N-1:0] long_v;
    rri_pins_t        lvl_s, rise_s, long_s;
    logic [CNT_W-1:0] pulse_min_q;

    assign pin_v  = pins;
    assign lvl_s  = lvl_v;
    assign rise_s = rise_v;
    assign long_s = long_v;

    // Every contact gets the same sampling and width check
    generate
        for (genvar i = 0; i < PIN_N; i++) begin : g_pin
            rri_contact #(
                .CNT_W      (CNT_W)
            ) u_contact (
                .clk        (clk),
                .rst        (rst),
                .pin        (pin_v[i]),
                .min_cyc    (pulse_min_q),
                .lvl        (lvl_v[i]),
                .rise       (rise_v[i]),
                .long_pulse (long_v[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    rri_ctrl_t         ctrl_q;
    logic [FREQ_W-1:0] setpoint_q;
    logic [FREQ_W-1:0] preset_q [PRESET_N];
    rri_run_t          state_q, state_d;

    wire       hit_ctrl   = (addr == OFF_CTRL);
    wire       hit_status = (addr == OFF_STATUS);
    wire       hit_pmin   = (addr == OFF_PULSE_MIN);
    wire       hit_setp   = (addr == OFF_SETPOINT);
    wire       hit_preset = (addr[ADDR_W-1:5] == OFF_PRESET0[ADDR_W-1:5]) && (addr[1:0] == 2'h0);
    wire [2:0] preset_idx = addr[4:2];

    // Writes; status is read-only and unmapped writes are dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q      <= CTRL_RST;
            setpoint_q  <= SETPOINT_RST;
            pulse_min_q <= CNT_W'(PULSE_MIN_CYC);
        end else if (wr_en) begin
            if (hit_ctrl)
                ctrl_q <= wdata[CTRL_W-1:0];
            if (hit_setp)
                setpoint_q <= wdata[FREQ_W-1:0];
            if (hit_pmin)
                pulse_min_q <= wdata[CNT_W-1:0];
        end
    end

    // Preset table kept in its own array
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < PRESET_N; k++)
                preset_q[k] <= PRESET_RST;
        end else if (wr_en && hit_preset) begin
            preset_q[preset_idx] <= wdata[FREQ_W-1:0];
        end
    end

    // Read data selection
    wire [DATA_W-1:0] status_w = {
        {(DATA_W-ST_PINS_LSB-PIN_N){1'b0}}, lvl_v,
        fault_cond, fault_q, remote_mode_q, output_inhibit_q, preset_active_q, state_q
    };
    wire [DATA_W-1:0] rd_word =
        hit_ctrl   ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_q}        :
        hit_status ? status_w                                  :
        hit_pmin   ? {{(DATA_W-CNT_W){1'b0}}, pulse_min_q}     :
        hit_setp   ? {{(DATA_W-FREQ_W){1'b0}}, setpoint_q}     :
        hit_preset ? {{(DATA_W-FREQ_W){1'b0}}, preset_q[preset_idx]} :
                     {DATA_W{1'b0}};

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            rdata_q <= '0;
        else
            rdata_q <= rd_en ? rd_word : '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control mode
    wire is_remote = (ctrl_q.ctl_mode == CM_REMOTE) ||
                     ((ctrl_q.ctl_mode == CM_BY_REMOTE) && lvl_s.remote_en);

    ////////////////////////////////////////////////////////////////////////////
    // Fault and reset handling
    wire reset_evt   = rise_s.ext_reset || rise_s.local_reset;
    wire fault_clear = reset_evt && fault_q && !fault_cond;
    wire fault_d     = fault_trip || (fault_q && !fault_clear);
    wire freset_d    = fault_clear && !fault_trip;                          // A new trip wins

    ////////////////////////////////////////////////////////////////////////////
    // Run state; reset never touches it, so running through a reset carries on
    wire      run_ok    = lvl_s.drive_enable && !fault_q && !fault_trip;
    rri_run_t lvl_next;
    rri_run_t pulse_next;
    rri_run_t cmd_next;

    assign lvl_next   = lvl_s.start ? ST_FWD :
                        lvl_s.stop  ? ST_REV : ST_IDLE;
    assign pulse_next = long_s.start ? ST_FWD :
                        (long_s.stop && ctrl_q.permit_stop) ? ST_IDLE : state_q;
    assign cmd_next   = !is_remote        ? state_q    :
                        ctrl_q.pulse_mode ? pulse_next : lvl_next;
    assign state_d    = run_ok ? cmd_next : ST_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Reference frequency from the speed contacts
    wire [2:0] spd      = lvl_s.speed;
    wire [2:0] prio_idx = spd[2] ? 3'h3 : spd[1] ? 3'h2 : spd[0] ? 3'h1 : 3'h0;
    wire [2:0] sel_idx  = ctrl_q.sel_priority ? prio_idx : spd;
    wire       use_di   = ctrl_q.open_loop && ctrl_q.src_di;
    wire [FREQ_W-1:0] freq_d = use_di ? preset_q[sel_idx] : setpoint_q;

    ////////////////////////////////////////////////////////////////////////////
    // State and outputs, all registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q          <= ST_IDLE;
            run_fwd_q        <= 1'b0;
            run_rev_q        <= 1'b0;
            output_inhibit_q <= 1'b1;
            remote_mode_q    <= 1'b0;
            freq_ref_q       <= '0;
            preset_active_q  <= 1'b0;
            fault_q          <= 1'b0;
            fault_reset_q    <= 1'b0;
        end else begin
            state_q          <= state_d;
            run_fwd_q        <= (state_d == ST_FWD);
            run_rev_q        <= (state_d == ST_REV);
            output_inhibit_q <= !lvl_s.drive_enable || fault_d;  // coast, no ramp
            remote_mode_q    <= is_remote;
            freq_ref_q       <= freq_d;
            preset_active_q  <= use_di;
            fault_q          <= fault_d;
            fault_reset_q    <= freset_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_level_fwd;
        (is_remote && !ctrl_q.pulse_mode && run_ok && lvl_s.start) |=> run_fwd_q && state_q == ST_FWD;
    endproperty
    a_level_fwd: assert property (p_level_fwd) else $error("level start did not run forward");

    property p_level_rev;
        (is_remote && !ctrl_q.pulse_mode && run_ok && !lvl_s.start && lvl_s.stop) |=> run_rev_q;
    endproperty
    a_level_rev: assert property (p_level_rev) else $error("level stop did not run reverse");

    property p_level_open;
        (is_remote && !ctrl_q.pulse_mode && !lvl_s.start && !lvl_s.stop) |=> !run_fwd_q && !run_rev_q;
    endproperty
    a_level_open: assert property (p_level_open) else $error("drive kept running with contacts open");

    property p_pulse_start;
        (is_remote && ctrl_q.pulse_mode && run_ok && long_s.start) |=> run_fwd_q;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("long start pulse ignored");

    property p_pulse_cause;
        ($rose(run_fwd_q) && $past(ctrl_q.pulse_mode)) |-> $past(long_s.start);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse mode started without long pulse");

    property p_pulse_stop;
        (is_remote && ctrl_q.pulse_mode && ctrl_q.permit_stop && long_s.stop && !long_s.start)
            |=> state_q == ST_IDLE ##1 !run_fwd_q;
    endproperty
    a_pulse_stop: assert property (p_pulse_stop) else $error("permitted stop pulse ignored");

    property p_inhibit;
        !lvl_s.drive_enable |=> output_inhibit_q && !run_fwd_q && !run_rev_q;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("running while drive enable open");

    property p_not_remote;
        (!is_remote && run_ok) |=> $stable(state_q);
    endproperty
    a_not_remote: assert property (p_not_remote) else $error("start or stop acted outside remote");

    property p_remote_en;
        (ctrl_q.ctl_mode == CM_BY_REMOTE) |=> remote_mode_q == $past(lvl_s.remote_en);
    endproperty
    a_remote_en: assert property (p_remote_en) else $error("remote enable not followed");

    property p_reset_nofault;
        (reset_evt && !fault_q && !fault_trip) |=> !fault_q && !fault_reset_q;
    endproperty
    a_reset_nofault: assert property (p_reset_nofault) else $error("reset without fault had effect");

    property p_reset_run;
        (reset_evt && state_q == ST_FWD && run_ok && !long_s.stop && (ctrl_q.pulse_mode || lvl_s.start))
            |=> run_fwd_q;
    endproperty
    a_reset_run: assert property (p_reset_run) else $error("reset stopped a running drive");

    property p_reset_clear;
        (rise_s.ext_reset && fault_q && !fault_cond && !fault_trip) |=> !fault_q && fault_reset_q ##1 !fault_reset_q;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("cleared fault not restored");

    property p_freq_src;
        !use_di |=> freq_ref_q == $past(setpoint_q) && !preset_active_q;
    endproperty
    a_freq_src: assert property (p_freq_src) else $error("speed contacts read when not selected");

    property p_freq_di;
        (use_di && !ctrl_q.sel_priority) |=> freq_ref_q == $past(preset_q[spd]);
    endproperty
    a_freq_di: assert property (p_freq_di) else $error("wrong preset chosen");

    c_pulse_start: cover property (ctrl_q.pulse_mode && $rose(run_fwd_q));
    c_level_rev:   cover property (!ctrl_q.pulse_mode && $rose(run_rev_q));
    c_fault_clear: cover property (fault_reset_q);
    c_preset:      cover property (preset_active_q && spd == 3'h5);

endmodule : rri_top

// ### shared/rri_pkg.sv
// Constants, types and register map for the remote run input logic.
// Assumes one 40 MHz system clock and contacts arriving unsynchronised on pins.
//
// Behaviour
// - Start and stop inputs work in level or pulse form, chosen by configuration.
// - Level mode, remote active: run forward while start closed, stop on open.
// - Pulse mode: start only after start closes then opens, closed over 500 ms.
// - Level mode: run reverse while stop closed and start open, stop when it opens.
// - With pulse stop permitted, a stop pulse closed over 500 ms stops the drive.
// - Drive-enable contact open inhibits output and coasts; running needs it closed.
// - Three speed contacts pick the reference frequency per configured selection.
// - Speed contacts are read only in open loop with discrete-input setpoint source.
// - In remote-by-contact mode, remote-enable contact closed means remote control.
// - External reset closing acts exactly like the local cabinet reset button.
// - A reset with no fault present leaves operation unchanged.
// - A reset while running does not shut the drive down.
// - After the fault condition is gone, a reset returns the drive to normal.
package rri_pkg;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PULSE_MIN = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SETPOINT  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PRESET0   = 8'h20;
    localparam int PRESET_N = 8;
    localparam int FREQ_W   = 16;

    // Timing: least closed time of a valid pulse
    localparam int unsigned CLK_HZ           = 40_000_000;
    localparam int unsigned PULSE_MIN_MS     = 500;
    localparam int unsigned PULSE_MIN_CYC_DEF = PULSE_MIN_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 25;

    // Control modes
    localparam logic [1:0] CM_LOCAL     = 2'h0;
    localparam logic [1:0] CM_REMOTE    = 2'h1;
    localparam logic [1:0] CM_BY_REMOTE = 2'h2;

    // Control register layout, reset value all zero (local, level, closed loop)
    typedef struct packed {
        logic       sel_priority;  // 1: highest closed speed wins, 0: binary code
        logic       src_di;        // Setpoint source is the speed contacts
        logic       open_loop;     // Run mode open loop
        logic [1:0] ctl_mode;      // Control mode
        logic       permit_stop;   // Pulse stop permitted
        logic       pulse_mode;    // 1: pulse form, 0: level form
    } rri_ctrl_t;
    localparam int CTRL_W = 7;
    localparam rri_ctrl_t CTRL_RST = 7'h00;
    localparam logic [FREQ_W-1:0] SETPOINT_RST = 16'h0000;
    localparam logic [FREQ_W-1:0] PRESET_RST   = 16'h0000;

    // Status register field positions
    localparam int ST_STATE_LSB  = 0;
    localparam int ST_PRESET_BIT = 3;
    localparam int ST_INHIB_BIT  = 4;
    localparam int ST_REMOTE_BIT = 5;
    localparam int ST_FAULT_BIT  = 6;
    localparam int ST_COND_BIT   = 7;
    localparam int ST_PINS_LSB   = 8;

    // Contacts of the upper terminal strip plus the cabinet reset button
    typedef struct packed {
        logic       local_reset;
        logic       ext_reset;
        logic       remote_en;
        logic [2:0] speed;
        logic       drive_enable;
        logic       stop;
        logic       start;
    } rri_pins_t;
    localparam int PIN_N = 9;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FWD  = 3'b010,
        ST_REV  = 3'b100
    } rri_run_t;

endpackage : rri_pkg

// ### testbench/rri_contacts_model.sv
// Remote operator contacts for the remote run input logic.
// Assumes dry contacts: closed drives 1, open drives 0, changed after clk edges.
module rri_contacts_model (
    input  wire logic        clk,
    output rri_pkg::rri_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import rri_pkg::*;

    logic [PIN_N-1:0] pins_q;

    // Contacts start open; an open dry contact reads a firm 0
    initial pins_q = '0;
    assign pins = pins_q;

    ////////////////////////////////////////////////////////////////////////
    // Hold one contact at a level until told otherwise
    task set_pin(input int i, input logic v);
        @(posedge clk);
        pins_q[i] <= v;
    endtask : set_pin

    // Close for n clock cycles then open; short pulses serve both refusal tests and the reset contacts
    task pulse_pin(input int i, input int n);
        @(posedge clk);
        pins_q[i] <= 1'b1;
        repeat (n) @(posedge clk);
        pins_q[i] <= 1'b0;
    endtask : pulse_pin
endmodule : rri_contacts_model

// ### testbench/tb.sv
// Self-checking bench for the remote run input logic top.
// Assumes a 40 MHz clock and a pulse minimum shortened to 20 cycles.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rri_pkg::*;

    localparam int MIN_CYC = 20;
    localparam int P_START = 0;
    localparam int P_STOP  = 1;
    localparam int P_EN    = 2;
    localparam int P_REM   = 6;
    localparam int P_XRST  = 7;

    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic              fault_trip = 1'b0;
    logic              fault_cond = 1'b0;
    rri_pins_t         pins;
    logic [DATA_W-1:0] rdata_q;
    logic              run_fwd_q, run_rev_q, output_inhibit_q, remote_mode_q;
    logic [FREQ_W-1:0] freq_ref_q;
    logic              preset_active_q, fault_q, fault_reset_q;
    logic [DATA_W-1:0] d;
    int                n_errors = 0;
    int                cmp_count = 0;

    // Half period 12.5 ns
    always #12.5 clk = ~clk;

    rri_contacts_model m_u (.clk(clk), .pins(pins));

    rri_top #(.PULSE_MIN_CYC(MIN_CYC)) dut_u (
        .clk(clk), .rst(rst), .pins(pins), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
        .fault_trip(fault_trip), .fault_cond(fault_cond),
        .run_fwd_q(run_fwd_q), .run_rev_q(run_rev_q),
        .output_inhibit_q(output_inhibit_q), .remote_mode_q(remote_mode_q),
        .freq_ref_q(freq_ref_q), .preset_active_q(preset_active_q),
        .fault_q(fault_q), .fault_reset_q(fault_reset_q));

    ////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata_q;
    endtask : rd

    // Margin past sync chain plus pulse-width decision
    task settle;
        repeat (8) @(posedge clk);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    // Watchdog so a hang still reaches the verdict
    initial begin
        #2500000;
        n_errors++;
        $display("Error at %0t: run did not finish", $time);
        finish_test;
    end

    initial begin
        int i;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1 chk(output_inhibit_q, 32'h1);
        rd(OFF_CTRL);
        chk(d, 32'h0);
        rd(OFF_PULSE_MIN);
        chk(d, MIN_CYC);
        // Status is read-only: still idle and inhibited after a write
        wr(OFF_STATUS, 32'hffff_ffff);
        rd(OFF_STATUS);
        chk(d, 32'h11);
        rd(8'h40);
        chk(d, 32'h0);
        // Local control: start contact must do nothing
        m_u.set_pin(P_EN, 1'b1);
        m_u.set_pin(P_START, 1'b1);
        settle;
        chk(output_inhibit_q, 32'h0);
        chk(run_fwd_q, 32'h0);
        // Remote, level form
        wr(OFF_CTRL, 32'h04);
        settle;
        chk(run_fwd_q, 32'h1);
        rd(OFF_STATUS);
        chk(d[2:0], 3'h2);
        m_u.set_pin(P_START, 1'b0);
        settle;
        chk(run_fwd_q, 32'h0);
        m_u.set_pin(P_STOP, 1'b1);
        settle;
        chk(run_rev_q, 32'h1);
        m_u.set_pin(P_EN, 1'b0);
        settle;
        chk(output_inhibit_q, 32'h1);
        chk(run_rev_q, 32'h0);
        m_u.set_pin(P_EN, 1'b1);
        m_u.set_pin(P_STOP, 1'b0);
        settle;
        chk(run_rev_q, 32'h0);
        // Pulse form, stop permitted: closed exactly the minimum is refused, one more cycle taken
        wr(OFF_CTRL, 32'h07);
        m_u.pulse_pin(P_START, MIN_CYC);
        settle;
        chk(run_fwd_q, 32'h0);
        m_u.pulse_pin(P_START, MIN_CYC + 1);
        settle;
        chk(run_fwd_q, 32'h1);
        m_u.pulse_pin(P_STOP, MIN_CYC);
        settle;
        chk(run_fwd_q, 32'h1);
        m_u.pulse_pin(P_STOP, MIN_CYC + 1);
        settle;
        chk(run_fwd_q, 32'h0);
        // Remote chosen by contact
        wr(OFF_CTRL, 32'h08);
        m_u.set_pin(P_REM, 1'b1);
        settle;
        chk(remote_mode_q, 32'h1);
        m_u.set_pin(P_REM, 1'b0);
        settle;
        chk(remote_mode_q, 32'h0);
        // Speed contacts, binary code then priority
        for (i = 0; i < PRESET_N; i++)
            wr(OFF_PRESET0 + 8'(4 * i), 32'h100 + i);
        wr(OFF_SETPOINT, 32'h55);
        wr(OFF_CTRL, 32'h30);
        for (i = 0; i < 8; i++) begin
            m_u.set_pin(3, i[0]);
            m_u.set_pin(4, i[1]);
            m_u.set_pin(5, i[2]);
            settle;
            chk(freq_ref_q, 32'h100 + i);
        end
        chk(preset_active_q, 32'h1);
        wr(OFF_CTRL, 32'h70);
        m_u.set_pin(5, 1'b0);
        settle;
        chk(freq_ref_q, 32'h102);
        wr(OFF_CTRL, 32'h20);
        settle;
        chk(preset_active_q, 32'h0);
        chk(freq_ref_q, 32'h55);
        // Resets: remote level run, both reset contacts in turn
        wr(OFF_CTRL, 32'h04);
        m_u.set_pin(P_START, 1'b1);
        for (i = P_XRST; i <= P_XRST + 1; i++) begin
            m_u.pulse_pin(i, 3);
            settle;
            chk(fault_q, 32'h0);
            chk(run_fwd_q, 32'h1);
            @(posedge clk) fault_trip <= 1'b1;
            fault_cond <= 1'b1;
            @(posedge clk) fault_trip <= 1'b0;
            settle;
            chk(fault_q, 32'h1);
            chk(run_fwd_q, 32'h0);
            m_u.pulse_pin(i, 3);
            settle;
            chk(fault_q, 32'h1);
            @(posedge clk) fault_cond <= 1'b0;
            m_u.pulse_pin(i, 3);
            // Clear pulse stands one cycle: look just after each edge
            repeat (12) begin
                @(posedge clk);
                #1;
                if (fault_reset_q === 1'b1) break;
            end
            chk(fault_reset_q, 32'h1);
            settle;
            chk(fault_q, 32'h0);
            chk(run_fwd_q, 32'h1);
        end
        finish_test;
    end
endmodule : tb
